//--- rtl/iit_pkg.sv
// Package for the interrupt interval timer: register map, fields, resets.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package iit_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] IIT_OFF_CTRL   = 4'h0;
  localparam logic [3:0] IIT_OFF_PERIOD = 4'h4;
  localparam logic [3:0] IIT_OFF_COUNT  = 4'h8;
  localparam logic [3:0] IIT_OFF_POWER  = 4'hc;
  // ----------------------------------------------------------------
  // Control and power register fields, reset values and constants
  // ----------------------------------------------------------------
  localparam int IIT_CTRL_DIV_LSB   = 0;
  localparam int IIT_CTRL_DIV_W     = 4;
  localparam int IIT_CTRL_ENABLE    = 4;
  localparam int IIT_CTRL_REPEAT    = 5;
  localparam int IIT_CTRL_SHUTDOWN  = 6;
  localparam int IIT_CTRL_IRQ_EN    = 8;
  localparam int IIT_PWR_TIMER_OFF  = 4;
  localparam logic [5:0] IIT_CTRL_LOW_RST = 6'h00;
  localparam logic [15:0] IIT_COUNT_RST   = 16'h0000;
  localparam logic [15:0] IIT_VECTOR      = 16'h0010;
  localparam logic [31:0] IIT_UNMAPPED    = 32'h0000_0000;
  localparam int IIT_CNT_W = 16;
endpackage

//--- rtl/iit_prescaler.sv
// Prescaler: half-rate clock enable, then binary division by 2**select.
// Assumes one core clock; all rates are one-cycle enable pulses.
`timescale 1ns/1ps
module iit_prescaler import iit_pkg::*; #(
  parameter int SEL_W = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Control
  input  wire logic             run,
  input  wire logic [SEL_W-1:0] clock_divider_select,
  // Output tick
  output logic                  tick
);
  localparam int DW = (1 << SEL_W);

  logic          half_q;
  logic [DW-1:0] div_q;
  logic [DW-1:0] mask;

  // ----------------------------------------------------------------
  // Half-rate clock output enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  assign mask = (DW'(1) << clock_divider_select) - DW'(1);

  // Stopped divider burns no toggles while shut down
  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      div_q <= '0;
    end else if (half_q) begin
      div_q <= div_q + DW'(1);
    end
  end

  // Code 0 passes the half rate, each code doubles the ratio
  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      tick <= 1'b0;
    end else begin
      tick <= half_q && ((div_q & mask) == mask);
    end
  end
endmodule

//--- rtl/iit_down_counter.sv
// 16-bit down counter with load, reload and single-pulse zero event.
// Assumes tick and load come from logic on the same clock.
`timescale 1ns/1ps
module iit_down_counter import iit_pkg::*; #(
  parameter int W = IIT_CNT_W
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Control
  input  wire logic         tick,
  input  wire logic         enable,
  input  wire logic         repeat_en,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  input  wire logic [W-1:0] period,
  // Status
  output logic [W-1:0]      count_q,
  output logic              active_q,
  output logic              zero_pulse_q
);
  // ----------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q  <= IIT_COUNT_RST;
      active_q <= 1'b0;
    end else if (load) begin
      count_q  <= load_value;
      active_q <= 1'b1;
    end else if (tick && enable && active_q) begin
      if (count_q == W'(1) || count_q == '0) begin
        // Reaching zero: reload or park inactive
        count_q  <= repeat_en ? period : '0;
        active_q <= repeat_en;
      end else begin
        count_q <= count_q - W'(1);
      end
    end
  end

  // One pulse per arrival at zero; loading zero fires on the next tick
  always_ff @(posedge core_clk) begin
    if (rst || load) begin
      zero_pulse_q <= 1'b0;
    end else begin
      zero_pulse_q <= tick && enable && active_q
                      && (count_q == W'(1) || count_q == '0);
    end
  end
endmodule

//--- rtl/iit_timer.sv
// Interrupt interval timer top: Avalon-MM registers, prescaler, counter.
// Assumes a single 250 MHz core clock and a synchronous active-high reset.
`timescale 1ns/1ps
module iit_timer import iit_pkg::*; (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt to core
  output logic             irq_pulse_q,
  output logic [15:0]      irq_vector_q,
  // Half-rate clock output enable
  output logic             clock_output_q
);
  logic [5:0]  ctrl_low_q;
  logic        irq_en_q;
  logic        timer_power_off_q;
  logic [15:0] period_q;
  logic [15:0] load_value_q;
  logic        load_q;
  logic        ack_q;
  logic        run;
  logic        tick;
  logic [15:0] count;
  logic        active;
  logic        zero_pulse;
  logic        wr;
  logic        rd;
  logic [31:0] rd_d;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait state per access keeps read data registered
  assign wr = avs_write && !ack_q;
  assign rd = avs_read && !ack_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // Registered twin of !ack_q so the pin comes straight from a flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // ----------------------------------------------------------------
  // Control and power registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_low_q        <= IIT_CTRL_LOW_RST;
      irq_en_q          <= 1'b0;
      timer_power_off_q <= 1'b0;
    end else if (wr && avs_byteenable[0] && avs_address == IIT_OFF_CTRL) begin
      ctrl_low_q <= avs_writedata[5:0];
      // Shutdown bit lives in bit 6; written 0 to resume
      timer_power_off_q <= timer_power_off_q;
    end else if (wr && avs_byteenable[0] && avs_address == IIT_OFF_POWER) begin
      timer_power_off_q <= avs_writedata[IIT_PWR_TIMER_OFF];
    end
    if (!rst && wr && avs_byteenable[1] && avs_address == IIT_OFF_CTRL) begin
      irq_en_q <= avs_writedata[IIT_CTRL_IRQ_EN];
    end
  end

  logic shutdown_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shutdown_q <= 1'b0;
    end else if (wr && avs_byteenable[0] && avs_address == IIT_OFF_CTRL) begin
      shutdown_q <= avs_writedata[IIT_CTRL_SHUTDOWN];
    end
  end

  assign run = !shutdown_q && !timer_power_off_q;

  // ----------------------------------------------------------------
  // Period and load
  // ----------------------------------------------------------------
  // Period has no reset: it keeps its value through chip reset
  always_ff @(posedge core_clk) begin
    if (wr && avs_address == IIT_OFF_PERIOD) begin
      period_q <= avs_writedata[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      load_value_q <= 16'h0000;
      load_q       <= 1'b0;
    end else begin
      load_q <= wr && avs_address == IIT_OFF_PERIOD;
      if (wr && avs_address == IIT_OFF_PERIOD) begin
        load_value_q <= avs_writedata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  // Enable gates prescaler and counter in the same cycle; a restart can lose one period
  iit_prescaler #(
    .SEL_W (IIT_CTRL_DIV_W)
  ) u_prescaler (
    .core_clk             (core_clk),
    .rst                  (rst),
    .run                  (run && ctrl_low_q[IIT_CTRL_ENABLE]),
    .clock_divider_select (ctrl_low_q[IIT_CTRL_DIV_LSB +: IIT_CTRL_DIV_W]),
    .tick                 (tick)
  );

  iit_down_counter #(
    .W (IIT_CNT_W)
  ) u_counter (
    .core_clk     (core_clk),
    .rst          (rst),
    .tick         (tick),
    .enable       (run && ctrl_low_q[IIT_CTRL_ENABLE]),
    .repeat_en    (ctrl_low_q[IIT_CTRL_REPEAT]),
    .load         (load_q),
    .load_value   (load_value_q),
    .period       (period_q),
    .count_q      (count),
    .active_q     (active),
    .zero_pulse_q (zero_pulse)
  );

  // ----------------------------------------------------------------
  // Interrupt and clock output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_pulse_q  <= 1'b0;
      irq_vector_q <= 16'h0000;
    end else begin
      irq_pulse_q  <= zero_pulse && irq_en_q;
      irq_vector_q <= IIT_VECTOR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clock_output_q <= 1'b0;
    end else begin
      clock_output_q <= ~clock_output_q;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_d = IIT_UNMAPPED;
    case (avs_address)
      IIT_OFF_CTRL: begin
        rd_d[5:0]            = ctrl_low_q;
        rd_d[IIT_CTRL_SHUTDOWN] = shutdown_q;
        rd_d[7]              = active;
        rd_d[IIT_CTRL_IRQ_EN] = irq_en_q;
      end
      IIT_OFF_PERIOD: rd_d[15:0] = period_q;
      IIT_OFF_COUNT:  rd_d[15:0] = count;
      IIT_OFF_POWER:  rd_d[IIT_PWR_TIMER_OFF] = timer_power_off_q;
      default:        rd_d = IIT_UNMAPPED;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd) begin
      avs_readdata <= rd_d;
    end
  end
endmodule

//--- verification/iit_timer_asserts.sv
// Checker for the interval timer: bus handshake, interrupt pulse, clock output.
// Assumes it is bound to iit_timer and sees only that module's ports.
`timescale 1ns/1ps
module iit_timer_chk import iit_pkg::*; (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Avalon-MM slave
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Interrupt and clock output
  input wire logic        irq_pulse_q,
  input wire logic [15:0] irq_vector_q,
  input wire logic        clock_output_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----
  // Properties
  // ----
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  req_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait state");
  ans_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  irq_single_a: assert property (irq_pulse_q |=> !irq_pulse_q)
    else $error("interrupt pulse wider than one cycle");
  irq_vector_a: assert property (irq_pulse_q |-> irq_vector_q == IIT_VECTOR)
    else $error("wrong interrupt vector");
  reset_quiet_a: assert property ($fell(rst) |-> (!irq_pulse_q) [*8])
    else $error("interrupt right after reset");
  clk_half_a: assert property (clock_output_q |=> !clock_output_q)
    else $error("clock output not at half rate");
  clk_rise_a: assert property (!clock_output_q |=> clock_output_q)
    else $error("clock output stuck low");
  unmapped_zero_a: assert property (
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00
    |-> avs_readdata == IIT_UNMAPPED)
    else $error("unmapped read not zero");
  count_width_a: assert property (
    avs_read && !avs_waitrequest && avs_address == IIT_OFF_COUNT
    |-> avs_readdata[31:16] == 16'h0000)
    else $error("count wider than 16 bits");
endmodule
bind iit_timer iit_timer_chk u_chk (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq_pulse_q(irq_pulse_q),
  .irq_vector_q(irq_vector_q), .clock_output_q(clock_output_q));

//--- verification/tb_top.sv
// Bench for the interval timer: Avalon-MM tasks, one task per scenario.
// Assumes one wait state per access and a tick every 2*2**select cycles.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module tb_top import iit_pkg::*;;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, q, c1;
  logic        avs_waitrequest, irq_pulse_q, clock_output_q;
  logic [15:0] irq_vector_q, vec;
  int          error_cnt = 0, total_checks = 0, cyc = 0, last = 0, gap = 0, irq_n = 0;
  always #2 core_clk = ~core_clk;
  iit_timer dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq_pulse_q(irq_pulse_q), .irq_vector_q(irq_vector_q), .clock_output_q(clock_output_q));
  // Pulse counter; gap is the spacing of the last two pulses
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (irq_pulse_q === 1'b1) begin
      irq_n <= irq_n + 1;
      gap <= cyc - last;
      last <= cyc;
      vec <= irq_vector_q;
    end
  end
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk);
    // Only the watchdog ends a wait that never gets an answer
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wait_irq(input int tgt);
    int t;
    t = 0;
    while (irq_n < tgt && t < 3000) begin
      @(posedge core_clk);
      t++;
    end
    if (irq_n < tgt) begin
      error_cnt++;
      $display("MISMATCH t=%0t interrupt never came", $time);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset_vals();
    bus(0, IIT_OFF_CTRL, 0);
    `CHK(q[5:0], IIT_CTRL_LOW_RST)
    bus(0, IIT_OFF_COUNT, 0);
    `CHK(q[15:0], IIT_COUNT_RST)
    bus(1, 4'h1, 32'hffff);
    bus(0, 4'h1, 0);
    `CHK(q, IIT_UNMAPPED)
  endtask
  task automatic t_one_shot();
    int n0;
    n0 = irq_n;
    // Lane 1 off: the interrupt-enable bit 8 in bits 15:8 must not change
    avs_byteenable <= 4'h1;
    bus(1, IIT_OFF_CTRL, 32'h100);
    avs_byteenable <= 4'hf;
    bus(0, IIT_OFF_CTRL, 0);
    `CHK(q[8], 1'b0)
    bus(1, IIT_OFF_CTRL, 32'h110);
    bus(1, IIT_OFF_PERIOD, 32'h0008);
    bus(0, IIT_OFF_PERIOD, 0);
    `CHK(q[15:0], 16'h0008)
    wait_irq(n0 + 1);
    `CHK(vec, IIT_VECTOR)
    idle(80);
    `CHK(irq_n, n0 + 1)
    `CHK(irq_pulse_q, 1'b0)
    bus(0, IIT_OFF_COUNT, 0);
    `CHK(q[15:0], 16'h0000)
    bus(0, IIT_OFF_CTRL, 0);
    `CHK(q[7], 1'b0)
  endtask
  task automatic t_rates();
    int g [8];
    // Period 2 gives two ticks per interrupt, a tick every 2 << code cycles
    for (int s = 0; s < 8; s++) begin
      bus(1, IIT_OFF_CTRL, 32'h130 | s);
      bus(1, IIT_OFF_PERIOD, 32'h0002);
      wait_irq(irq_n + 4);
      g[s] = gap;
      `CHK(g[s], 4 << s)
      if (s > 0) `CHK(g[s], 2 * g[s-1])
    end
  endtask
  task automatic t_hold();
    bus(1, IIT_OFF_CTRL, 32'h010);
    bus(1, IIT_OFF_PERIOD, 32'h0100);
    idle(20);
    bus(1, IIT_OFF_CTRL, 32'h000);
    bus(0, IIT_OFF_COUNT, 0);
    c1 = q;
    idle(40);
    bus(0, IIT_OFF_COUNT, 0);
    `CHK(q, c1)
    `CHK(c1[15:0] < 16'h0100, 1'b1)
    bus(1, IIT_OFF_CTRL, 32'h010);
    idle(20);
    bus(0, IIT_OFF_COUNT, 0);
    `CHK(q[15:0] < c1[15:0] && q[15:0] + 16'd20 > c1[15:0], 1'b1)
  endtask
  task automatic t_shutdown();
    bus(1, IIT_OFF_PERIOD, 32'hffff);
    for (int i = 0; i < 2; i++) begin
      bus(1, i ? IIT_OFF_POWER : IIT_OFF_CTRL, i ? 32'h10 : 32'h50);
      bus(0, IIT_OFF_COUNT, 0);
      c1 = q;
      idle(30);
      bus(0, IIT_OFF_COUNT, 0);
      `CHK(q, c1)
      bus(1, i ? IIT_OFF_POWER : IIT_OFF_CTRL, i ? 32'h0 : 32'h10);
      idle(10);
      bus(0, IIT_OFF_COUNT, 0);
      `CHK(q[15:0] < c1[15:0], 1'b1)
    end
  endtask
  task automatic t_quiet();
    int n0;
    n0 = irq_n;
    bus(1, IIT_OFF_PERIOD, 32'h0002);
    idle(40);
    `CHK(irq_n, n0)
    bus(1, IIT_OFF_CTRL, 32'h000);
    bus(1, IIT_OFF_PERIOD, 32'h1234);
    rst <= 1'b1;
    idle(4);
    rst <= 1'b0;
    idle(1);
    t_reset_vals();
    bus(0, IIT_OFF_PERIOD, 0);
    `CHK(q[15:0], 16'h1234)
    `CHK(irq_n, n0)
  endtask
  task automatic close_out();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset_vals();
    t_one_shot();
    t_rates();
    t_hold();
    t_shutdown();
    t_quiet();
    close_out();
  end
  // Generous bound: the scenarios need a few thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end
endmodule
